// ==== common/mae_pkg.sv ====
// Constants, field layouts and carrier types for the multiply and
// auxiliary-register modify execution unit.
// Assumes one core clock shared with fetch path and data memory.
package mae_pkg;
  localparam logic [7:0]  OPHI_MODIFY  = 8'h8B;
  localparam logic [7:0]  OPHI_MPY     = 8'h54;
  localparam logic [7:0]  OPHI_MPY_ADD = 8'h50;
  localparam logic [7:0]  OPHI_MPY_SUB = 8'h51;
  localparam logic [15:0] LONG_MPY_WORD = 16'hBE80;
  localparam logic [2:0]  SHORT_MPY_TOP = 3'h6;
  localparam int          FORM_BIT     = 7;
  localparam int          NAR_BIT      = 3;
  localparam int          RPT_W        = 8;
  localparam int          T1_W         = 5;
  localparam int          T2_W         = 4;
  // Indirect modification codes in opcode bits 6:4
  localparam logic [2:0]  MOD_DEC    = 3'h1;
  localparam logic [2:0]  MOD_INC    = 3'h2;
  localparam logic [2:0]  MOD_BRDEC  = 3'h4;
  localparam logic [2:0]  MOD_IDXDEC = 3'h5;
  localparam logic [2:0]  MOD_IDXINC = 3'h6;
  localparam logic [2:0]  MOD_BRINC  = 3'h7;
  // Product shift settings
  localparam logic [1:0]  PM_L1   = 2'h1;
  localparam logic [1:0]  PM_L4   = 2'h2;
  localparam logic [1:0]  PM_RSH6 = 2'h3;
  // Cycle figures
  localparam logic [15:0] CYC_ONE  = 16'h0001;
  localparam logic [15:0] CYC_LONG = 16'h0002;
  // Register byte offsets
  localparam logic [7:0]  A_CTRL  = 8'h00;
  localparam logic [7:0]  A_DPAGE = 8'h04;
  localparam logic [7:0]  A_WAIT  = 8'h08;
  localparam logic [7:0]  A_ACC   = 8'h0C;
  localparam logic [7:0]  A_PRODUCT_REGISTER  = 8'h10;
  localparam logic [7:0]  A_MULTIPLICAND_REG = 8'h14;
  localparam logic [7:0]  A_SECOND_TEMP_REG = 8'h18;
  localparam logic [7:0]  A_THIRD_TEMP_REG = 8'h1C;
  localparam logic [7:0]  A_STAT  = 8'h20;
  localparam logic [7:0]  A_INDEX_REG  = 8'h24;
  localparam logic [7:0]  A_AUX_COMPARE_REG  = 8'h28;
  localparam logic [7:0]  A_TLOAD = 8'h2C;
  localparam logic [7:0]  A_PC    = 8'h30;
  localparam logic [7:0]  A_AR0   = 8'h40;
  // Control register fields
  localparam int C_NDX = 0;
  localparam int C_TRM = 1;
  localparam int C_SXM = 2;
  localparam int C_OVM = 3;
  localparam int C_PM  = 4;
  localparam int C_CEXT = 6;
  localparam int C_OEXT = 7;
  localparam int C_SHR  = 8;
  localparam int CTRL_W = 9;
  localparam logic [CTRL_W-1:0] RST_CTRL = 9'h003;
  // Status register fields
  localparam int S_ARP = 0;
  localparam int S_ARB = 3;
  localparam int S_C   = 6;
  localparam int S_OV  = 7;
  localparam int S_REF = 8;
  localparam int S_BSY = 9;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_FETCH = 2'h1,
    ST_EXEC  = 2'h2,
    ST_HOLD  = 2'h3
  } mae_state_e;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_MOD  = 3'h1,
    OP_MPY  = 3'h2,
    OP_MADD = 3'h3,
    OP_MSUB = 3'h4
  } mae_op_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } mae_apb_req_s;

  typedef struct packed {
    logic             valid;
    logic [15:0]      word;
    logic [15:0]      ext;
    logic [RPT_W-1:0] rpt_n;
    logic             legacy;
  } mae_issue_s;
endpackage : mae_pkg

// ==== rtl/mae_exec.sv ====
// Execution unit for aux-register modify, multiply, multiply-add and
// multiply-subtract, with an APB slave for its state and control.
// Assumes fetch path and data memory run on clk_i; memory answers by
// data_valid_i in or after the cycle data_req_o is high.
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
module mae_exec
  import mae_pkg::*;
#(
  parameter int WAIT_W = 4
)(
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire mae_apb_req_s apb_i,
  output logic [31:0]       prdata_o,
  output logic              pready_o,
  output logic              pslverr_o,
  input  wire mae_issue_s   issue_i,
  output logic              instr_ready_o,
  output logic              data_req_o,
  output logic [15:0]       data_addr_o,
  input  wire logic [15:0]  data_word_i,
  input  wire logic         data_valid_i,
  output logic [15:0]       pc_o
);
  if (WAIT_W < 1 || WAIT_W > 6)
  begin : g_chk
    $error("WAIT_W must be 1 to 6");
  end

  logic [CTRL_W-1:0]   ctrl_reg;
  logic [8:0]          dp_reg;
  logic [2*WAIT_W-1:0] wait_reg;
  logic [31:0]         acc_reg;
  logic [31:0]         product_register_reg;
  logic [15:0]         t0_reg;
  logic [T1_W-1:0]     t1_reg;
  logic [T2_W-1:0]     t2_reg;
  logic [15:0]         index_reg_reg;
  logic [15:0]         aux_compare_reg_reg;
  logic [15:0]         ar_reg [0:7];
  logic [2:0]          arp_reg;
  logic [2:0]          arb_reg;
  logic                c_reg;
  logic                ov_reg;
  logic                ref_reg;
  logic [15:0]         pc_reg;
  mae_state_e          state_reg;
  mae_state_e          state_next;
  mae_op_e             op_reg;
  logic                imm_reg;
  logic [15:0]         kval_reg;
  logic                ind_reg;
  logic [6:0]          low_reg;
  logic                leg_reg;
  logic [RPT_W-1:0]    iter_reg;
  logic [15:0]         bud_reg;
  logic                ready_reg;
  logic                req_reg;
  logic [15:0]         addr_reg;
  logic [31:0]         prdata_reg;
  logic                pready_reg;
  logic                pslverr_reg;

  // Combinational decode and datapath
  mae_op_e          d_op;
  logic             d_imm;
  logic             d_long;
  logic [15:0]      d_k;
  logic [RPT_W-1:0] d_n;
  logic [15:0]      d_bud;
  logic             d_fetch;
  logic             accept;
  logic             exec_now;
  logic             last_it;
  logic [15:0]      opnd;
  logic [31:0]      prod;
  logic [31:0]      shp;
  logic [32:0]      sum;
  logic             ovf;
  logic [31:0]      acc_new;
  logic [2:0]       arp_new;
  logic [15:0]      ar_new;
  logic             wr_en;
  logic [31:0]      rd_data;
  logic             rd_ok;
  logic [WAIT_W-1:0] wp;
  logic [WAIT_W-1:0] wd;

  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      r[i] = v[15-i];
    end
    return r;
  endfunction : rev16

  function automatic logic [15:0] ar_step(input logic [15:0] a,
                                          input logic [2:0]  m,
                                          input logic [15:0] x);
    case (m)
      MOD_INC:    return a + 16'h0001;
      MOD_DEC:    return a - 16'h0001;
      MOD_IDXINC: return a + x;
      MOD_IDXDEC: return a - x;
      // Reverse-carry steps for FFT addressing
      MOD_BRINC:  return rev16(rev16(a) + rev16(x));
      MOD_BRDEC:  return rev16(rev16(a) - rev16(x));
      default:    return a;
    endcase
  endfunction : ar_step

  function automatic logic [31:0] pshift(input logic [31:0] p,
                                         input logic [1:0]  m);
    case (m)
      PM_L1:   return {p[30:0], 1'b0};
      PM_L4:   return {p[27:0], 4'h0};
      PM_RSH6: return {{6{p[31]}}, p[31:6]};
      default: return p;
    endcase
  endfunction : pshift

  assign wp = wait_reg[WAIT_W-1:0];
  assign wd = wait_reg[2*WAIT_W-1:WAIT_W];

  // Decode of the word offered on the issue port
  always_comb
  begin
    d_op   = OP_NONE;
    d_imm  = 1'b0;
    d_long = 1'b0;
    d_k    = 16'h0000;
    if (issue_i.word == LONG_MPY_WORD)
    begin
      d_op   = OP_MPY;
      d_imm  = 1'b1;
      d_long = 1'b1;
      d_k    = issue_i.ext;
    end
    else if (issue_i.word[15:13] == SHORT_MPY_TOP)
    begin
      d_op  = OP_MPY;
      d_imm = 1'b1;
      // Sign mode bit deliberately ignored here
      d_k   = {{3{issue_i.word[12]}}, issue_i.word[12:0]};
    end
    else
    begin
      case (issue_i.word[15:8])
        OPHI_MODIFY:  d_op = OP_MOD;
        OPHI_MPY:     d_op = OP_MPY;
        OPHI_MPY_ADD: d_op = OP_MADD;
        OPHI_MPY_SUB: d_op = OP_MSUB;
        default:      d_op = OP_NONE;
      endcase
    end
  end

  // Cycle budget per memory placement
  always_comb
  begin
    logic ce;
    logic oe;
    logic [15:0] n16;
    ce  = ctrl_reg[C_CEXT];
    oe  = ctrl_reg[C_OEXT];
    d_n = (issue_i.rpt_n == '0 || d_imm) ? RPT_W'(1) : issue_i.rpt_n;
    n16 = 16'(d_n);
    d_fetch = !d_imm && (d_op == OP_MPY || d_op == OP_MADD || d_op == OP_MSUB);
    if (d_long)
    begin
      d_bud = CYC_LONG + (ce ? 16'({wp, 1'b0}) : 16'h0000);
    end
    else if (d_imm)
    begin
      d_bud = CYC_ONE + (ce ? 16'(wp) : 16'h0000);
    end
    else if (!d_fetch)
    begin
      d_bud = n16 + (ce ? 16'(wp) : 16'h0000);
    end
    else
    begin
      d_bud = n16 + (oe ? 16'(n16 * 16'(wd)) : 16'h0000)
            + (ce ? 16'(wp) : 16'h0000)
            + ((oe && ce) ? CYC_ONE : 16'h0000)
            + ((ctrl_reg[C_SHR] && !oe && !ce) ? CYC_ONE : 16'h0000);
    end
  end

  assign accept   = (state_reg == ST_IDLE) && issue_i.valid;
  assign exec_now = (state_reg == ST_EXEC) ||
                    (state_reg == ST_FETCH && data_valid_i);
  assign last_it  = (iter_reg <= RPT_W'(1));

  // Arithmetic for one iteration
  always_comb
  begin
    opnd = imm_reg ? kval_reg : data_word_i;
    prod = $signed(t0_reg) * $signed(opnd);
    shp  = pshift(product_register_reg, ctrl_reg[C_PM+1:C_PM]);
    if (op_reg == OP_MSUB)
    begin
      sum = {1'b0, acc_reg} - {1'b0, shp};
      ovf = (acc_reg[31] != shp[31]) && (sum[31] != acc_reg[31]);
    end
    else
    begin
      sum = {1'b0, acc_reg} + {1'b0, shp};
      ovf = (acc_reg[31] == shp[31]) && (sum[31] != acc_reg[31]);
    end
    acc_new = sum[31:0];
    if (ovf && ctrl_reg[C_OVM])
    begin
      acc_new = acc_reg[31] ? 32'h8000_0000 : 32'h7FFF_FFFF;
    end
    arp_new = low_reg[NAR_BIT] ? low_reg[2:0] : arp_reg;
    ar_new  = ar_step(ar_reg[arp_reg], low_reg[6:4], index_reg_reg);
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (issue_i.valid)
        begin
          state_next = d_fetch ? ST_FETCH : ST_EXEC;
        end
      end
      ST_FETCH, ST_EXEC:
      begin
        if (exec_now && last_it)
        begin
          state_next = (bud_reg <= CYC_ONE) ? ST_IDLE : ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        if (bud_reg <= CYC_ONE)
        begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_reg <= ST_IDLE;
      ready_reg <= 1'b0;
      req_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ready_reg <= (state_next == ST_IDLE);
      req_reg   <= (state_next == ST_FETCH);
    end
  end

  // Latched instruction context
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      op_reg   <= OP_NONE;
      imm_reg  <= 1'b0;
      kval_reg <= 16'h0000;
      ind_reg  <= 1'b0;
      low_reg  <= 7'h00;
      leg_reg  <= 1'b0;
      iter_reg <= '0;
      bud_reg  <= 16'h0000;
    end
    else if (accept)
    begin
      op_reg   <= d_op;
      imm_reg  <= d_imm;
      kval_reg <= d_k;
      // Immediate words carry constant bits in bit 7
      ind_reg  <= issue_i.word[FORM_BIT] && !d_imm;
      low_reg  <= issue_i.word[6:0];
      leg_reg  <= issue_i.legacy;
      iter_reg <= d_n;
      bud_reg  <= d_bud;
    end
    else
    begin
      if (exec_now)
      begin
        iter_reg <= iter_reg - RPT_W'(1);
      end
      if (bud_reg != 16'h0000)
      begin
        bud_reg <= bud_reg - CYC_ONE;
      end
    end
  end

  // Operand address; a repeated direct form keeps its address
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      addr_reg <= 16'h0000;
    end
    else if (accept)
    begin
      addr_reg <= issue_i.word[FORM_BIT] ? ar_reg[arp_reg]
                                         : {dp_reg, issue_i.word[6:0]};
    end
    else if (exec_now && ind_reg)
    begin
      addr_reg <= (arp_new == arp_reg) ? ar_new : ar_reg[arp_new];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pc_reg <= 16'h0000;
    end
    else if (accept)
    begin
      pc_reg <= pc_reg + (d_long ? 16'h0002 : 16'h0001);
    end
    else if (wr_en && apb_i.paddr == A_PC)
    begin
      pc_reg <= apb_i.pwdata[15:0];
    end
  end

  // APB slave: answers in the first access cycle
  assign wr_en = apb_i.psel && apb_i.penable && pready_reg && apb_i.pwrite;

  always_comb
  begin
    rd_ok   = 1'b1;
    rd_data = 32'h0000_0000;
    if (apb_i.paddr[7:5] == A_AR0[7:5] && apb_i.paddr[1:0] == 2'h0)
    begin
      rd_data = {16'h0000, ar_reg[apb_i.paddr[4:2]]};
    end
    else
    begin
      case (apb_i.paddr)
        A_CTRL:  rd_data = 32'(ctrl_reg);
        A_DPAGE: rd_data = 32'(dp_reg);
        A_WAIT:  rd_data = 32'(wait_reg);
        A_ACC:   rd_data = acc_reg;
        A_PRODUCT_REGISTER:  rd_data = product_register_reg;
        A_MULTIPLICAND_REG: rd_data = 32'(t0_reg);
        A_SECOND_TEMP_REG: rd_data = 32'(t1_reg);
        A_THIRD_TEMP_REG: rd_data = 32'(t2_reg);
        A_STAT:  rd_data = 32'({(state_reg != ST_IDLE), ref_reg, ov_reg,
                                c_reg, arb_reg, arp_reg});
        A_INDEX_REG:  rd_data = 32'(index_reg_reg);
        A_AUX_COMPARE_REG:  rd_data = 32'(aux_compare_reg_reg);
        A_TLOAD: rd_data = 32'(t0_reg);
        A_PC:    rd_data = 32'(pc_reg);
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= apb_i.psel && !apb_i.penable;
      if (apb_i.psel && !apb_i.penable)
      begin
        pslverr_reg <= !rd_ok;
        prdata_reg  <= rd_ok ? rd_data : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ctrl_reg <= RST_CTRL;
      dp_reg   <= 9'h000;
      wait_reg <= '0;
    end
    else if (wr_en)
    begin
      case (apb_i.paddr)
        A_CTRL:  ctrl_reg <= apb_i.pwdata[CTRL_W-1:0];
        A_DPAGE: dp_reg   <= apb_i.pwdata[8:0];
        A_WAIT:  wait_reg <= apb_i.pwdata[2*WAIT_W-1:0];
        default: ;
      endcase
    end
  end

  // Temporaries; a legacy load mirrors into all three unless disabled
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      t0_reg <= 16'h0000;
      t1_reg <= '0;
      t2_reg <= '0;
    end
    else if (wr_en)
    begin
      case (apb_i.paddr)
        A_MULTIPLICAND_REG: t0_reg <= apb_i.pwdata[15:0];
        A_SECOND_TEMP_REG: t1_reg <= apb_i.pwdata[T1_W-1:0];
        A_THIRD_TEMP_REG: t2_reg <= apb_i.pwdata[T2_W-1:0];
        A_TLOAD:
        begin
          t0_reg <= apb_i.pwdata[15:0];
          if (!ctrl_reg[C_TRM])
          begin
            t1_reg <= apb_i.pwdata[T1_W-1:0];
            t2_reg <= apb_i.pwdata[T2_W-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Product register: execution wins over a same-cycle bus write
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      product_register_reg <= 32'h0000_0000;
    end
    else if (exec_now && op_reg != OP_MOD && op_reg != OP_NONE)
    begin
      product_register_reg <= prod;
    end
    else if (wr_en && apb_i.paddr == A_PRODUCT_REGISTER)
    begin
      product_register_reg <= apb_i.pwdata;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      acc_reg <= 32'h0000_0000;
      c_reg   <= 1'b0;
      ov_reg  <= 1'b0;
    end
    else if (exec_now && (op_reg == OP_MADD || op_reg == OP_MSUB))
    begin
      acc_reg <= acc_new;
      // Borrow shows as a clear carry on subtract
      c_reg   <= (op_reg == OP_MSUB) ? !sum[32] : sum[32];
      // Overflow latches; cleared only by software
      ov_reg  <= ov_reg || ovf;
    end
    else if (wr_en && apb_i.paddr == A_ACC)
    begin
      acc_reg <= apb_i.pwdata;
    end
    else if (wr_en && apb_i.paddr == A_STAT)
    begin
      c_reg <= apb_i.pwdata[S_C];
      if (apb_i.pwdata[S_OV])
      begin
        ov_reg <= 1'b0;
      end
    end
  end

  // Refused repeat of an immediate form: sticky, set beats clear
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ref_reg <= 1'b0;
    end
    else if (accept && d_imm && issue_i.rpt_n > RPT_W'(1))
    begin
      ref_reg <= 1'b1;
    end
    else if (wr_en && apb_i.paddr == A_STAT && apb_i.pwdata[S_REF])
    begin
      ref_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      arp_reg <= 3'h0;
      arb_reg <= 3'h0;
    end
    else if (exec_now && ind_reg && low_reg[NAR_BIT] && op_reg != OP_NONE)
    begin
      arb_reg <= arp_reg;
      arp_reg <= arp_new;
    end
    else if (wr_en && apb_i.paddr == A_STAT)
    begin
      arp_reg <= apb_i.pwdata[S_ARP+2:S_ARP];
      arb_reg <= apb_i.pwdata[S_ARB+2:S_ARB];
    end
  end

  // Auxiliary registers; memory word itself is never written here
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < 8; i++)
      begin
        ar_reg[i] <= 16'h0000;
      end
    end
    else if (exec_now && ind_reg && op_reg != OP_NONE)
    begin
      ar_reg[arp_reg] <= ar_new;
    end
    else if (wr_en && apb_i.paddr[7:5] == A_AR0[7:5] && apb_i.paddr[1:0] == 2'h0)
    begin
      ar_reg[apb_i.paddr[4:2]] <= apb_i.pwdata[15:0];
    end
  end

  // Index and compare registers follow AR0 in legacy mode while control bit NDX is clear
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      index_reg_reg <= 16'h0000;
      aux_compare_reg_reg <= 16'h0000;
    end
    else if (exec_now && ind_reg && leg_reg && op_reg != OP_NONE
             && !ctrl_reg[C_NDX] && arp_reg == 3'h0)
    begin
      index_reg_reg <= ar_new;
      aux_compare_reg_reg <= ar_new;
    end
    else if (wr_en && apb_i.paddr == A_INDEX_REG)
    begin
      index_reg_reg <= apb_i.pwdata[15:0];
    end
    else if (wr_en && apb_i.paddr == A_AUX_COMPARE_REG)
    begin
      aux_compare_reg_reg <= apb_i.pwdata[15:0];
    end
  end

  assign prdata_o      = prdata_reg;
  assign pready_o      = pready_reg;
  assign pslverr_o     = pslverr_reg;
  assign instr_ready_o = ready_reg;
  assign data_req_o    = req_reg;
  assign data_addr_o   = addr_reg;
  assign pc_o          = pc_reg;
endmodule : mae_exec

// ==== tb/mae_exec_properties.sv ====
// Assertions on the issue and operand ports of mae_exec.
// Assumes a bind to every mae_exec instance.
`timescale 1ns/1ps
module mae_exec_properties
  import mae_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire mae_issue_s  issue_i,
  input wire logic        instr_ready_o,
  input wire logic        data_req_o,
  input wire logic        data_valid_i,
  input wire logic [15:0] data_addr_o,
  input wire logic [15:0] pc_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  logic       tk;
  logic       mu;
  logic       md;
  logic [6:0] off_reg;
  assign tk = issue_i.valid & instr_ready_o;
  assign md = issue_i.word[15:8] == OPHI_MODIFY;
  assign mu = issue_i.word[15:8] inside {OPHI_MPY, OPHI_MPY_ADD, OPHI_MPY_SUB};
  // Offset kept, the request comes cycles later
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      off_reg <= 7'h0;
    else if (tk)
      off_reg <= issue_i.word[6:0];
  end
  a_mod_direct_pc: assert property (tk && md && !issue_i.word[7] |=>
    pc_o == $past(pc_o) + 16'h1 && !data_req_o) else $error("direct modify not a no-op");
  a_mod_no_read: assert property (tk && md |=> !data_req_o [*2])
    else $error("modify touched memory");
  a_mul_pc_one: assert property (tk && mu |=> pc_o == $past(pc_o) + 16'h1)
    else $error("multiply pc step");
  a_long_pc_two: assert property (tk && issue_i.word == LONG_MPY_WORD |=>
    pc_o == $past(pc_o) + 16'h2) else $error("long immediate pc step");
  a_short_no_read: assert property (tk && issue_i.word[15:13] == SHORT_MPY_TOP |=>
    !data_req_o [*2]) else $error("short immediate read memory");
  a_direct_offset: assert property (tk && mu && !issue_i.word[7] |=>
    ##[0:40] (data_req_o && data_addr_o[6:0] == off_reg)) else $error("operand address");
  a_req_holds: assert property (data_req_o && !data_valid_i |=>
    data_req_o && $stable(data_addr_o)) else $error("request dropped");
  a_busy_after_take: assert property (tk |=> !instr_ready_o)
    else $error("ready after take");
endmodule : mae_exec_properties

bind mae_exec mae_exec_properties i_mae_exec_properties (.clk_i(clk_i), .reset_i(reset_i),
  .issue_i(issue_i), .instr_ready_o(instr_ready_o), .data_req_o(data_req_o),
  .data_valid_i(data_valid_i), .data_addr_o(data_addr_o), .pc_o(pc_o));

// ==== tb/mae_exec_tb.sv ====
// Self-checking bench for mae_exec over APB and the issue port.
// Assumes mae_pkg and the bound checker are compiled first.
`timescale 1ns/1ps
module mae_exec_tb
  import mae_pkg::*;
;
  logic         clk_i, reset_i, pready_o, pslverr_o, instr_ready_o;
  logic         data_req_o, data_valid_i;
  logic [31:0]  prdata_o;
  logic [15:0]  data_addr_o, data_word_i, pc_o, pc;
  mae_apb_req_s apb_i;
  mae_issue_s   issue_i;
  logic [15:0]  mem [128];
  logic [31:0]  qe [$];
  logic [7:0]   qa [$];
  int           errors, n_tests, cyc;

  mae_exec i_mae_exec (.clk_i(clk_i), .reset_i(reset_i), .apb_i(apb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .issue_i(issue_i), .instr_ready_o(instr_ready_o), .data_req_o(data_req_o),
    .data_addr_o(data_addr_o), .data_word_i(data_word_i),
    .data_valid_i(data_valid_i), .pc_o(pc_o));

  always #2 clk_i = ~clk_i;

  // Memory answers every other cycle so the request must hold
  always @(posedge clk_i)
  begin
    data_valid_i <= data_req_o & ~data_valid_i;
    data_word_i  <= mem[data_addr_o[6:0]];
  end

  always @(posedge clk_i)
    if (apb_i.psel && apb_i.penable && pready_o === 1'b1 && !apb_i.pwrite)
    begin
      n_tests++;
      if (prdata_o !== qe[0])
      begin
        $display("[FAIL] reg %h exp %h got %h", qa[0], qe[0], prdata_o);
        errors++;
      end
      // Only the last probe address is unmapped
      if (pslverr_o !== (qa[0] == 8'hFC))
      begin
        $display("[FAIL] slverr %h got %b", qa[0], pslverr_o);
        errors++;
      end
      void'(qa.pop_front());
      void'(qe.pop_front());
    end

  function automatic logic [31:0] mul(input logic [15:0] a, input logic [15:0] b);
    logic signed [31:0] x, y;
    x = $signed(a);
    y = $signed(b);
    return x * y;
  endfunction : mul

  task automatic conclude;
    $display("TB: %0d checks, %0d errors", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  task automatic tmo(input int k);
    if (k >= 200)
    begin
      errors++;
      conclude();
    end
  endtask : tmo

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    apb_i <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    apb_i.penable <= 1'b1;
    for (k = 0; k < 200; k++)
    begin
      @(posedge clk_i);
      if (pready_o === 1'b1)
        break;
    end
    tmo(k);
    apb_i <= '0;
    @(posedge clk_i);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    qa.push_back(a);
    qe.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic wait_rdy;
    int k;
    for (k = 0; k < 200 && instr_ready_o !== 1'b1; k++)
      @(posedge clk_i);
    cyc = k;
    tmo(k);
  endtask : wait_rdy

  // Edges from take to ready, minus the decode cycle
  task automatic chk(input int e);
    n_tests++;
    if (cyc != e || pc_o !== pc)
    begin
      $display("[FAIL] cycles/pc exp %0d/%h got %0d/%h", e, pc, cyc, pc_o);
      errors++;
    end
  endtask : chk

  task automatic op(input logic [15:0] w, input logic [15:0] x, input logic [7:0] n,
                    input logic lg);
    wait_rdy();
    issue_i <= '{1'b1, w, x, n, lg};
    @(posedge clk_i);
    issue_i.valid <= 1'b0;
    @(posedge clk_i);
    wait_rdy();
  endtask : op

  initial
  begin
    logic [15:0] t, k;
    logic [31:0] acc, pr, r, sp;
    logic [32:0] s;
    logic        c, v;
    void'($urandom(32'h55ec));
    clk_i = 1'b0;
    reset_i = 1'b1;
    apb_i = '0;
    issue_i = '0;
    data_valid_i = 1'b0;
    data_word_i = 16'h0;
    errors = 0;
    n_tests = 0;
    pc = 16'h0;
    t = 16'h0;
    foreach (mem[i]) mem[i] = 16'($urandom);
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd(A_CTRL, 32'h003);
    rd(A_STAT, 32'h0);
    apb(1'b1, A_DPAGE, 32'h6);
    repeat (4)
    begin
      t = 16'($urandom);
      k = 16'($urandom) & 16'h007F;
      apb(1'b1, A_MULTIPLICAND_REG, {16'h0, t});
      op({OPHI_MPY, 1'b0, k[6:0]}, 16'h0, 8'h0, 1'b0);
      pc = pc + 16'h1;
      // One cycle plus the bench memory's late answer
      chk(1 + 1);
      rd(A_PRODUCT_REGISTER, mul(t, mem[k[6:0]]));
      rd(A_PC, {16'h0, pc});
    end
    $display("TB: multiply done");
    for (int j = 0; j < 4; j++)
    begin
      acc = $urandom;
      pr = $urandom;
      k = 16'($urandom) & 16'h007F;
      apb(1'b1, A_ACC, acc);
      apb(1'b1, A_PRODUCT_REGISTER, pr);
      apb(1'b1, A_STAT, 32'h180);
      // Second half runs the right-shift-by-6 product path
      apb(1'b1, A_CTRL, j[1] ? 32'h033 : 32'h003);
      sp = j[1] ? 32'($signed(pr) >>> 6) : pr;
      op({j[0] ? OPHI_MPY_SUB : OPHI_MPY_ADD, 1'b0, k[6:0]}, 16'h0, 8'h0, 1'b0);
      s = j[0] ? {1'b0, acc} - {1'b0, sp} : {1'b0, acc} + {1'b0, sp};
      r = s[31:0];
      c = j[0] ? ~s[32] : s[32];
      v = (acc[31] ^ r[31]) & (j[0] ? acc[31] ^ sp[31] : ~(acc[31] ^ sp[31]));
      rd(A_ACC, r);
      rd(A_STAT, {24'h0, v, c, 6'h0});
      rd(A_PRODUCT_REGISTER, mul(t, mem[k[6:0]]));
    end
    pc = pc + 16'h4;
    $display("TB: accumulate done");
    k = 16'($urandom) | 16'h1000;
    apb(1'b1, A_STAT, 32'h180);
    // Code external with three wait states
    apb(1'b1, A_CTRL, 32'h043);
    apb(1'b1, A_WAIT, 32'h03);
    op({SHORT_MPY_TOP, k[12:0]}, 16'h0, 8'h3, 1'b0);
    pc = pc + 16'h1;
    chk(1 + 3);
    rd(A_PRODUCT_REGISTER, mul(t, {{3{k[12]}}, k[12:0]}));
    rd(A_STAT, 32'h100);
    k = 16'($urandom);
    op(LONG_MPY_WORD, k, 8'h0, 1'b0);
    pc = pc + 16'h2;
    chk(2 + 2 * 3);
    rd(A_PRODUCT_REGISTER, mul(t, k));
    rd(A_PC, {16'h0, pc});
    $display("TB: immediate done");
    apb(1'b1, A_STAT, 32'h181);
    apb(1'b1, A_AR0 + 8'h4, 32'h34);
    op({OPHI_MODIFY, 1'b1, MOD_INC, 1'b1, 3'h5}, 16'h0, 8'h0, 1'b0);
    pc = pc + 16'h1;
    chk(1 + 3);
    rd(A_AR0 + 8'h4, 32'h35);
    rd(A_STAT, 32'h0D);
    op({OPHI_MODIFY, 1'b0, 7'h0D}, 16'h0, 8'h2, 1'b0);
    pc = pc + 16'h1;
    chk(2 + 3);
    rd(A_STAT, 32'h0D);
    rd(A_PC, {16'h0, pc});
    k = 16'($urandom);
    apb(1'b1, A_CTRL, 32'h002);
    apb(1'b1, A_STAT, 32'h180);
    apb(1'b1, A_AR0, {16'h0, k});
    op({OPHI_MODIFY, 1'b1, MOD_INC, 4'h0}, 16'h0, 8'h0, 1'b1);
    rd(A_INDEX_REG, {16'h0, k + 16'h1});
    rd(A_AUX_COMPARE_REG, {16'h0, k + 16'h1});
    $display("TB: modify done");
    apb(1'b1, A_CTRL, 32'h001);
    apb(1'b1, A_TLOAD, 32'hFFFF_FFFF);
    rd(A_MULTIPLICAND_REG, 32'hFFFF);
    rd(A_SECOND_TEMP_REG, 32'h1F);
    rd(A_THIRD_TEMP_REG, 32'hF);
    rd(8'hFC, 32'h0);
    $display("TB: temporaries done");
    conclude();
  end
endmodule : mae_exec_tb
